// ### logic/drgl_top.sv
// region geometry decode, accept strobe and read latency tracking
`timescale 1ns/1ns
`include "drgl_cfg.svh"
module drgl_top (
  input  wire logic                          clk_i,                    // host clock
  input  wire logic                          rstn_i,                   // async reset, active low
  // region V geometry
  input  wire drgl_pkg::drgl_row_code_t      region_v_row_count_code_i,
  input  wire drgl_pkg::drgl_bank_code_t     region_v_bank_count_code_i,
  // region W geometry
  input  wire drgl_pkg::drgl_dev_count_t     region_w_device_count_i,
  input  wire logic                          region_w_paired_banks_i,
  input  wire logic                          region_w_divided_core_i,
  input  wire logic                          region_w_large_page_i,
  input  wire drgl_pkg::drgl_row_code_t      region_w_row_count_code_i,
  input  wire drgl_pkg::drgl_bank_code_t     region_w_bank_count_code_i,
  // timing and gearing
  input  wire drgl_pkg::drgl_delay_t         row_to_column_delay_field_i,
  input  wire drgl_pkg::drgl_delay_t         precharge_time_field_i,
  input  wire drgl_pkg::drgl_gear_e          clock_ratio_select_i,
  input  wire logic                          accept_output_registered_i,
  // host transaction start and channel phase
  input  wire logic                          start_read_i,             // one-cycle start of a read
  input  wire logic                          divided_channel_clock_i,  // pin from outside
  // read data from the channel cell
  input  wire logic [`DRGL_RDATA_W-1:0]      read_data_bus_a_i,
  input  wire logic [`DRGL_RDATA_W-1:0]      read_data_bus_b_i,
  // decoded region V geometry
  output drgl_pkg::drgl_rows_t               region_v_rows_o,
  output drgl_pkg::drgl_banks_t              region_v_banks_o,
  // decoded region W geometry
  output drgl_pkg::drgl_dev_count_t          region_w_devices_o,
  output logic                               region_w_dependent_o,
  output logic                               region_w_split_core_o,
  output logic [7:0]                         region_w_page_dualocts_o,
  output drgl_pkg::drgl_rows_t               region_w_rows_o,
  output drgl_pkg::drgl_banks_t              region_w_banks_o,
  output logic                               geometry_reserved_o,      // a reserved code is loaded
  output logic                               timing_odd_o,             // timing field off the bin set
  // transaction and read data
  output logic                               transaction_accept_o,
  output drgl_pkg::drgl_lat_t                read_latency_o,           // latency of last accepted read
  output logic                               read_valid_o,
  output logic [2*`DRGL_RDATA_W-1:0]         read_data_a_o,            // {fall, rise}
  output logic [2*`DRGL_RDATA_W-1:0]         read_data_b_o             // {fall, rise}
);
  import drgl_pkg::*;

  // decode a row code; zero for reserved codes
  function automatic drgl_rows_t rows_of(input drgl_row_code_t code);
    if (code >= `DRGL_ROW_CODE_MIN && code <= `DRGL_ROW_CODE_MAX) begin
      rows_of = `DRGL_ROW_BASE << (code - `DRGL_ROW_CODE_MIN);
    end else begin
      rows_of = 15'h0000;
    end
  endfunction

  // decode a bank code; zero for reserved codes
  function automatic drgl_banks_t banks_of(input drgl_bank_code_t code);
    if (code >= `DRGL_BANK_CODE_MIN && code <= `DRGL_BANK_CODE_MAX) begin
      banks_of = `DRGL_BANK_BASE << (code - `DRGL_BANK_CODE_MIN);
    end else begin
      banks_of = 6'h00;
    end
  endfunction

  // geometry decode
  drgl_rows_t  v_rows_d,  v_rows_q;    // region V rows per bank
  drgl_banks_t v_banks_d, v_banks_q;   // region V banks per device
  drgl_dev_count_t w_dev_d, w_dev_q;   // region W devices
  logic        w_dep_d,   w_dep_q;     // region W dependent banks
  logic        w_split_d, w_split_q;   // region W split core
  logic [7:0]  w_page_d,  w_page_q;    // region W page size
  drgl_rows_t  w_rows_d,  w_rows_q;    // region W rows per bank
  drgl_banks_t w_banks_d, w_banks_q;   // region W banks per device
  logic        rsv_d,     rsv_q;       // reserved code seen
  logic        todd_d,    todd_q;      // timing field unusual

  // next values of the decoded geometry
  always_comb begin
    v_rows_d  = rows_of(region_v_row_count_code_i);                    // R1
    v_banks_d = banks_of(region_v_bank_count_code_i);                  // R2
    w_dev_d   = region_w_device_count_i;                               // R3
    w_dep_d   = region_w_paired_banks_i;                               // R4
    w_split_d = region_w_divided_core_i;                               // R5
    w_page_d  = region_w_large_page_i ? `DRGL_PAGE_LARGE : `DRGL_PAGE_SMALL; // R6
    w_rows_d  = rows_of(region_w_row_count_code_i);                    // R7
    w_banks_d = banks_of(region_w_bank_count_code_i);                  // R8
    // flag reserved encodings; behaviour under them is not defined
    rsv_d = (v_rows_d == 15'h0000) || (w_rows_d == 15'h0000) ||
            (v_banks_d == 6'h00) || (w_banks_d == 6'h00) ||
            (region_w_device_count_i > `DRGL_DEV_MAX);                 // R16
    // timing fields outside the usual odd delay / even precharge steps
    todd_d = !row_to_column_delay_field_i[0] || precharge_time_field_i[0]; // R9
  end

  // register the decoded geometry
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      v_rows_q  <= 15'h0000;
      v_banks_q <= 6'h00;
      w_dev_q   <= 6'h00;
      w_dep_q   <= 1'b0;
      w_split_q <= 1'b0;
      w_page_q  <= 8'h00;
      w_rows_q  <= 15'h0000;
      w_banks_q <= 6'h00;
      rsv_q     <= 1'b0;
      todd_q    <= 1'b0;
    end else begin
      v_rows_q  <= v_rows_d;
      v_banks_q <= v_banks_d;
      w_dev_q   <= w_dev_d;
      w_dep_q   <= w_dep_d;
      w_split_q <= w_split_d;
      w_page_q  <= w_page_d;
      w_rows_q  <= w_rows_d;
      w_banks_q <= w_banks_d;
      rsv_q     <= rsv_d;
      todd_q    <= todd_d;
    end
  end

  // channel clock phase
  logic [2:0] ph_sync_d, ph_sync_q;   // three-stage synchroniser
  logic       phase_d,   phase_q;     // settled channel clock level

  // shift the pin in; level changes when stages two and three agree
  always_comb begin
    ph_sync_d = {ph_sync_q[1:0], divided_channel_clock_i};
    phase_d   = (ph_sync_q[1] == ph_sync_q[2]) ? ph_sync_q[2] : phase_q;
  end

  // register the synchroniser and the settled level
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ph_sync_q <= 3'h0;
      phase_q   <= 1'b0;
    end else begin
      ph_sync_q <= ph_sync_d;
      phase_q   <= phase_d;
    end
  end

  // latency lookup
  drgl_lat_t lat_now;   // latency for a read started this cycle

  // the late phase is a low channel clock level at the start
  drgl_latency u_latency (
    .gear_i       (clock_ratio_select_i),
    .delay_i      (row_to_column_delay_field_i),
    .late_phase_i (!phase_q),
    .latency_o    (lat_now)
  );

  // accept and read slots
  logic                  acc_d, acc_q;   // registered accept
  drgl_lat_t             lat_d, lat_q;   // last latency
  logic [`DRGL_DUE_W-1:0] due_d, due_q;  // one bit per future cycle
  logic                  rv_d,  rv_q;    // first read data due

  // track each read until its first data cycle
  always_comb begin
    acc_d = start_read_i;                                              // R14
    lat_d = start_read_i ? lat_now : lat_q;                            // R10
    // shift the slots; a new read marks the slot its latency points at
    due_d = {1'b0, due_q[`DRGL_DUE_W-1:1]};
    if (start_read_i) begin
      due_d[lat_now - 5'h01] = 1'b1;                                   // R11
    end
    rv_d = due_q[0];
  end

  // register accept, latency and slots
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      acc_q <= 1'b0;
      lat_q <= 5'h00;
      due_q <= '0;
      rv_q  <= 1'b0;
    end else begin
      acc_q <= acc_d;
      lat_q <= lat_d;
      due_q <= due_d;
      rv_q  <= rv_d;
    end
  end

  // double data rate capture
  logic [`DRGL_RDATA_W-1:0]   a_rise_q, b_rise_q;   // rising-edge samples
  logic [`DRGL_RDATA_W-1:0]   a_fall_q, b_fall_q;   // falling-edge samples
  logic [2*`DRGL_RDATA_W-1:0] a_pair_d, a_pair_q;   // bus A word
  logic [2*`DRGL_RDATA_W-1:0] b_pair_d, b_pair_q;   // bus B word

  // sample both buses on the rising edge
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      a_rise_q <= '0;
      b_rise_q <= '0;
    end else begin
      a_rise_q <= read_data_bus_a_i;                                   // R15
      b_rise_q <= read_data_bus_b_i;                                   // R15
    end
  end

  // sample both buses on the falling edge
  always_ff @(negedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      a_fall_q <= '0;
      b_fall_q <= '0;
    end else begin
      a_fall_q <= read_data_bus_a_i;                                   // R15
      b_fall_q <= read_data_bus_b_i;                                   // R15
    end
  end

  // pair the rise sample with the fall half-cycle after it
  always_comb begin
    a_pair_d = {a_fall_q, a_rise_q};
    b_pair_d = {b_fall_q, b_rise_q};
  end

  // register the paired words
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      a_pair_q <= '0;
      b_pair_q <= '0;
    end else begin
      a_pair_q <= a_pair_d;
      b_pair_q <= b_pair_d;
    end
  end

  // outputs, all from flops except the direct accept
  assign region_v_rows_o          = v_rows_q;
  assign region_v_banks_o         = v_banks_q;
  assign region_w_devices_o       = w_dev_q;
  assign region_w_dependent_o     = w_dep_q;
  assign region_w_split_core_o    = w_split_q;
  assign region_w_page_dualocts_o = w_page_q;
  assign region_w_rows_o          = w_rows_q;
  assign region_w_banks_o         = w_banks_q;
  assign geometry_reserved_o      = rsv_q;
  assign timing_odd_o             = todd_q;
  // clocked accept, or the start strobe passed straight through
  assign transaction_accept_o     = accept_output_registered_i ? acc_q : start_read_i; // R14
  assign read_latency_o           = lat_q;
  assign read_valid_o             = rv_q;
  assign read_data_a_o            = a_pair_q;
  assign read_data_b_o            = b_pair_q;

endmodule // drgl_top

// ### logic/drgl_cfg.svh
// constants for the region geometry and read latency block
// What this block does
// [R1] decode region V row code to rows
// [R2] decode region V bank code to banks
// [R3] region W device count from 6-bit field
// [R4] region W paired banks bit marks dependence
// [R5] region W divided core bit marks split
// [R6] region W page bit: 128 or 64 dualocts
// [R7] region W row code decoded like V
// [R8] decode region W bank code to banks
// [R9] host loads timing fields with bin values
// [R10] latency from gear, delay, bank, pending; the block uses gear, delay and clock phase only
// [R11] minimum latency: precharged bank, activate then read
// [R12] non 1:1 gearing: latency follows clock phase
// [R13] delay 7: 10/11 at 4:3, 15/16 at 2:1
// [R14] accept registered or straight from start strobe
// [R15] read buses captured on both clock edges
// [R16] reserved geometry codes never programmed
`ifndef DRGL_CFG_SVH
`define DRGL_CFG_SVH

// row code window and base
`define DRGL_ROW_CODE_MIN   4'h9
`define DRGL_ROW_CODE_MAX   4'hE
`define DRGL_ROW_BASE       15'h0200
// bank code window and base
`define DRGL_BANK_CODE_MIN  3'h2
`define DRGL_BANK_CODE_MAX  3'h5
`define DRGL_BANK_BASE      6'h04
// device count limit
`define DRGL_DEV_MAX        6'h20
// page sizes in dualocts
`define DRGL_PAGE_LARGE     8'h80
`define DRGL_PAGE_SMALL     8'h40
// row to column delay bin edges
`define DRGL_TRCD_7         4'h7
`define DRGL_TRCD_9         4'h9
// read latency table in host cycles, minimum per gear and delay bin
`define DRGL_LAT_11_T7      5'h08
`define DRGL_LAT_11_T9      5'h09
`define DRGL_LAT_11_T11     5'h09
`define DRGL_LAT_43_T7      5'h0A
`define DRGL_LAT_43_T9      5'h0A
`define DRGL_LAT_43_T11     5'h0B
`define DRGL_LAT_32_T7      5'h0B
`define DRGL_LAT_32_T9      5'h0C
`define DRGL_LAT_32_T11     5'h0C
`define DRGL_LAT_21_T7      5'h0F
`define DRGL_LAT_21_T9      5'h10
`define DRGL_LAT_21_T11     5'h11
// extra cycle when the start lands in the late phase
`define DRGL_LAT_PHASE_ADD  5'h01
// depth of the outstanding read slot vector
`define DRGL_DUE_W          32
// read data bus width
`define DRGL_RDATA_W        8

`endif

// ### logic/drgl_pkg.sv
// types for the region geometry and read latency block
package drgl_pkg;
  // gear ratio selection codes
  typedef enum logic [2:0] {
    DRGL_GEAR_1_1 = 3'h1,
    DRGL_GEAR_4_3 = 3'h2,
    DRGL_GEAR_3_2 = 3'h3,
    DRGL_GEAR_2_1 = 3'h4
  } drgl_gear_e;
  // geometry code, decoded size, latency and delay types
  typedef logic [3:0]  drgl_row_code_t;
  typedef logic [2:0]  drgl_bank_code_t;
  typedef logic [5:0]  drgl_dev_count_t;
  typedef logic [14:0] drgl_rows_t;
  typedef logic [5:0]  drgl_banks_t;
  typedef logic [4:0]  drgl_lat_t;
  typedef logic [3:0]  drgl_delay_t;
endpackage

// ### logic/drgl_latency.sv
// read latency lookup from gear, row to column delay and clock phase
`timescale 1ns/1ns
`include "drgl_cfg.svh"
module drgl_latency (
  input  wire drgl_pkg::drgl_gear_e  gear_i,        // clock_ratio_select
  input  wire drgl_pkg::drgl_delay_t delay_i,       // row_to_column_delay_field
  input  wire logic                  late_phase_i,  // start fell in the late channel phase
  output drgl_pkg::drgl_lat_t        latency_o      // host cycles, start to first data
);
  import drgl_pkg::*;

  logic [1:0] bin;      // delay bin: 0 for 7, 1 for 9, 2 for 11
  drgl_lat_t  base;     // minimum latency of the bin
  logic       phased;   // gear ratio with two minimum values

  // group delays into the three tabulated bins
  always_comb begin
    if (delay_i <= `DRGL_TRCD_7) begin
      bin = 2'h0;
    end else if (delay_i <= `DRGL_TRCD_9) begin
      bin = 2'h1;
    end else begin
      bin = 2'h2;
    end
  end

  // minimum latency of a precharged, unconstrained read
  always_comb begin
    phased = 1'b1;
    case (gear_i)
      DRGL_GEAR_1_1: begin
        phased = 1'b0;
        base = (bin == 2'h0) ? `DRGL_LAT_11_T7 : (bin == 2'h1) ? `DRGL_LAT_11_T9 : `DRGL_LAT_11_T11; // R11
      end
      DRGL_GEAR_4_3: begin
        base = (bin == 2'h0) ? `DRGL_LAT_43_T7 : (bin == 2'h1) ? `DRGL_LAT_43_T9 : `DRGL_LAT_43_T11; // R13
      end
      DRGL_GEAR_3_2: begin
        base = (bin == 2'h0) ? `DRGL_LAT_32_T7 : (bin == 2'h1) ? `DRGL_LAT_32_T9 : `DRGL_LAT_32_T11; // R10
      end
      DRGL_GEAR_2_1: begin
        base = (bin == 2'h0) ? `DRGL_LAT_21_T7 : (bin == 2'h1) ? `DRGL_LAT_21_T9 : `DRGL_LAT_21_T11; // R13
      end
      default: begin
        // unknown gear: 1:1 delay 7 latency, no phase cycle
        phased = 1'b0;
        base   = `DRGL_LAT_11_T7;
      end
    endcase
  end

  // the late phase adds one cycle except at 1:1 and unknown gears
  always_comb begin
    latency_o = base + ((phased && late_phase_i) ? `DRGL_LAT_PHASE_ADD : 5'h00); // R12
  end

endmodule // drgl_latency

// ### tb/drgl_chan_model.sv
// channel cell model: divided channel clock and double rate read data
`timescale 1ns/1ns
module drgl_chan_model (
  input  wire logic       clk_i,                    // host clock
  output logic            divided_channel_clock_o,  // free running divided clock
  output logic [7:0]      read_data_bus_a_o,        // read data, new value each host edge
  output logic [7:0]      read_data_bus_b_o         // read data, new value each host edge
);
  logic [7:0] pat_q;  // running data pattern
  // divided clock, offset from host edges so the phase is never a race
  initial begin
    divided_channel_clock_o = 1'b0;
    #3;
    // level holds two host cycles so the three-flop filter sees it settle
    forever #8 divided_channel_clock_o = ~divided_channel_clock_o;
  end
  // data changes shortly after every host edge, inside the hold window
  initial begin
    pat_q = 8'h5A;
    read_data_bus_a_o = 8'h00;
    read_data_bus_b_o = 8'hFF;
  end
  always @(clk_i) begin
    #1 pat_q = pat_q + 8'h3B;
    read_data_bus_a_o = pat_q;
    read_data_bus_b_o = ~pat_q ^ 8'hC3;
  end
endmodule // drgl_chan_model

// ### tb/drgl_top_sva.sv
// checker for geometry decode, accept strobe and read latency
`timescale 1ns/1ns
module drgl_top_sva (
  input wire logic                      clk_i,
  input wire logic                      rstn_i,
  input wire drgl_pkg::drgl_row_code_t  region_v_row_count_code_i,
  input wire drgl_pkg::drgl_dev_count_t region_w_device_count_i,
  input wire logic                      region_w_paired_banks_i,
  input wire logic                      region_w_divided_core_i,
  input wire logic                      region_w_large_page_i,
  input wire drgl_pkg::drgl_bank_code_t region_w_bank_count_code_i,
  input wire drgl_pkg::drgl_delay_t     row_to_column_delay_field_i,
  input wire drgl_pkg::drgl_gear_e      clock_ratio_select_i,
  input wire logic                      accept_output_registered_i,
  input wire logic                      start_read_i,
  input wire drgl_pkg::drgl_rows_t      region_v_rows_o,
  input wire drgl_pkg::drgl_dev_count_t region_w_devices_o,
  input wire logic                      region_w_dependent_o,
  input wire logic                      region_w_split_core_o,
  input wire logic [7:0]                region_w_page_dualocts_o,
  input wire drgl_pkg::drgl_banks_t     region_w_banks_o,
  input wire logic                      transaction_accept_o,
  input wire drgl_pkg::drgl_lat_t       read_latency_o,
  input wire logic                      read_valid_o
);
  import drgl_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  logic live_q;  // one edge seen since reset release
  logic live_d;  // next value
  // marks when decode outputs reflect sampled inputs
  always_comb live_d = 1'b1;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) live_q <= 1'b0;
    else live_q <= live_d;
  end
  // read at 1:1 gearing and delay 7
  sequence s_start_11_7;
    start_read_i && clock_ratio_select_i == DRGL_GEAR_1_1 && row_to_column_delay_field_i == 4'h7;
  endsequence
  sequence s_answer_8;
    read_latency_o == 5'h08 ##8 read_valid_o;
  endsequence
  // read at 2:1 gearing and delay 7
  sequence s_start_21_7;
    start_read_i && clock_ratio_select_i == DRGL_GEAR_2_1 && row_to_column_delay_field_i == 4'h7;
  endsequence
  AST_ACC_REG: assert property (accept_output_registered_i && $past(accept_output_registered_i) |->
    transaction_accept_o == $past(start_read_i)) else $error("registered accept wrong");
  AST_ACC_DIR: assert property (!accept_output_registered_i |->
    transaction_accept_o == start_read_i) else $error("direct accept wrong");
  AST_PAGE: assert property (live_q |->
    region_w_page_dualocts_o == ($past(region_w_large_page_i) ? 8'h80 : 8'h40)) else $error("page size wrong");
  AST_DEP: assert property (live_q |-> region_w_dependent_o == $past(region_w_paired_banks_i))
    else $error("paired banks wrong");
  AST_SPLIT: assert property (live_q |-> region_w_split_core_o == $past(region_w_divided_core_i))
    else $error("split core wrong");
  AST_DEVS: assert property (live_q && region_w_device_count_i <= 6'h20 |=>
    region_w_devices_o == $past(region_w_device_count_i)) else $error("device count wrong");
  AST_V_ROWS: assert property (region_v_row_count_code_i inside {[4'h9:4'hE]} |=>
    region_v_rows_o == (15'h0200 << ($past(region_v_row_count_code_i) - 4'h9))) else $error("v rows wrong");
  AST_W_BANKS: assert property (region_w_bank_count_code_i inside {[3'h2:3'h5]} |=>
    region_w_banks_o == (6'h04 << ($past(region_w_bank_count_code_i) - 3'h2))) else $error("w banks wrong");
  AST_LAT_11: assert property (s_start_11_7 |=> s_answer_8)
    else $error("latency at 1:1 wrong");
  AST_LAT_21: assert property (s_start_21_7 |-> ##[16:17] read_valid_o)
    else $error("latency at 2:1 wrong");
endmodule // drgl_top_sva
bind drgl_top drgl_top_sva u_sva (.clk_i(clk_i), .rstn_i(rstn_i),
  .region_v_row_count_code_i(region_v_row_count_code_i), .region_w_device_count_i(region_w_device_count_i),
  .region_w_paired_banks_i(region_w_paired_banks_i), .region_w_divided_core_i(region_w_divided_core_i),
  .region_w_large_page_i(region_w_large_page_i), .region_w_bank_count_code_i(region_w_bank_count_code_i),
  .row_to_column_delay_field_i(row_to_column_delay_field_i), .clock_ratio_select_i(clock_ratio_select_i),
  .accept_output_registered_i(accept_output_registered_i), .start_read_i(start_read_i),
  .region_v_rows_o(region_v_rows_o), .region_w_devices_o(region_w_devices_o),
  .region_w_dependent_o(region_w_dependent_o), .region_w_split_core_o(region_w_split_core_o),
  .region_w_page_dualocts_o(region_w_page_dualocts_o), .region_w_banks_o(region_w_banks_o),
  .transaction_accept_o(transaction_accept_o), .read_latency_o(read_latency_o), .read_valid_o(read_valid_o));

// ### tb/drgl_top_test.sv
// testbench for geometry decode, accept strobe and read latency
`timescale 1ns/1ns
module drgl_top_test;
  import drgl_pkg::*;
  logic clk_i, rstn_i, w_pair, w_core, w_page, acc_reg, start, chan_clk;
  logic [3:0] v_row, w_row, delay;
  logic [2:0] v_bank, w_bank;
  logic [5:0] w_dev, w_devs_o, v_banks_o, w_banks_o;
  drgl_gear_e gear;
  logic [7:0] bus_a, bus_b, page_o;
  logic [14:0] v_rows_o, w_rows_o;
  logic dep_o, split_o, accept_o, valid_o, rsv_o, odd_o;
  logic [4:0] lat_o;
  logic [15:0] data_a_o, data_b_o;
  int n_errors = 0;
  int tests_run = 0;
  drgl_top dut (.clk_i(clk_i), .rstn_i(rstn_i), .region_v_row_count_code_i(v_row),
    .region_v_bank_count_code_i(v_bank), .region_w_device_count_i(w_dev), .region_w_paired_banks_i(w_pair),
    .region_w_divided_core_i(w_core), .region_w_large_page_i(w_page), .region_w_row_count_code_i(w_row),
    .region_w_bank_count_code_i(w_bank), .row_to_column_delay_field_i(delay), .precharge_time_field_i(4'h8),
    .clock_ratio_select_i(gear), .accept_output_registered_i(acc_reg), .start_read_i(start),
    .divided_channel_clock_i(chan_clk), .read_data_bus_a_i(bus_a), .read_data_bus_b_i(bus_b),
    .region_v_rows_o(v_rows_o), .region_v_banks_o(v_banks_o), .region_w_devices_o(w_devs_o),
    .region_w_dependent_o(dep_o), .region_w_split_core_o(split_o), .region_w_page_dualocts_o(page_o),
    .region_w_rows_o(w_rows_o), .region_w_banks_o(w_banks_o), .geometry_reserved_o(rsv_o),
    .timing_odd_o(odd_o), .transaction_accept_o(accept_o), .read_latency_o(lat_o), .read_valid_o(valid_o),
    .read_data_a_o(data_a_o), .read_data_b_o(data_b_o));
  drgl_chan_model u_chan (.clk_i(clk_i), .divided_channel_clock_o(chan_clk),
    .read_data_bus_a_o(bus_a), .read_data_bus_b_o(bus_b));
  // clock
  always #2 clk_i = ~clk_i;
  // one comparison
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // verdict
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // every legal geometry code and flag, reserved codes never loaded
  task automatic t_geometry;
    for (int i = 0; i < 6; i++) begin
      v_row = 4'h9 + 4'(i); w_row = 4'hE - 4'(i);
      v_bank = 3'h2 + 3'(i % 4); w_bank = 3'h5 - 3'(i % 4);
      w_pair = i[0]; w_core = ~i[0]; w_page = i[1]; w_dev = (i == 5) ? 6'h20 : 6'(i * 7);
      @(posedge clk_i) #1;
      check(16'(v_rows_o), 16'(15'h0200 << i), "v rows");
      check(16'(v_banks_o), 16'(6'h04 << (i % 4)), "v banks");
      check(16'(w_devs_o), 16'(w_dev), "w devices");
      check(16'(dep_o), 16'(i[0]), "w dependent");
      check(16'(split_o), {15'h0000, ~i[0]}, "w split");
      check(16'(page_o), i[1] ? 16'h0080 : 16'h0040, "w page");
      check(16'(w_rows_o), 16'(15'h4000 >> i), "w rows");
      check(16'(w_banks_o), 16'(6'h20 >> (i % 4)), "w banks");
      check(16'(rsv_o), 16'h0, "reserved flag");
      check(16'(odd_o), 16'h0, "timing flag");
    end
    $display("geometry test done");
  endtask
  // back to back starts in both accept modes
  task automatic t_accept;
    for (int m = 0; m < 2; m++) begin
      acc_reg = m[0];
      @(posedge clk_i) #1 start = 1'b1;
      #1 check(16'(accept_o), 16'(!m), "accept same cycle");
      @(posedge clk_i) #1 check(16'(accept_o), 16'h1, "accept first");
      @(posedge clk_i) #1 start = 1'b0;
      #1 check(16'(accept_o), 16'(m), "accept second");
      @(posedge clk_i) #1 check(16'(accept_o), 16'h0, "accept low");
      repeat (25) @(posedge clk_i);
      #1;
    end
    $display("accept test done");
  endtask
  // single read per gear and delay bin, bank idle
  task automatic t_latency;
    int n, k, lo, hi;
    int mins[12] = '{8, 9, 9, 10, 10, 11, 11, 12, 12, 15, 16, 17};
    for (k = 0; k < 12; k++) begin
      gear = drgl_gear_e'(3'(k / 3 + 1)); delay = 4'(7 + 2 * (k % 3));
      lo = mins[k]; hi = lo + ((k < 3) ? 0 : 1);
      @(posedge clk_i) #1 start = 1'b1;
      @(posedge clk_i) #1 start = 1'b0;
      n = 0;
      do begin @(posedge clk_i) #1 n++; end while (valid_o !== 1'b1 && n < 40);
      check(16'(n >= lo && n <= hi), 16'h1, "latency range");
      check(16'(lat_o), 16'(n), "latency output");
      @(posedge clk_i) #1 check(16'(valid_o), 16'h0, "valid pulse");
      repeat (4) @(posedge clk_i);
      #1;
    end
    $display("latency test done");
  endtask
  // both edge capture of the two read buses
  task automatic t_ddr;
    logic [7:0] ra, rb, fa, fb;
    @(posedge clk_i) begin ra = bus_a; rb = bus_b; end
    @(negedge clk_i) begin fa = bus_a; fb = bus_b; end
    @(posedge clk_i) #1;
    check(data_a_o, {fa, ra}, "bus a capture");
    check(data_b_o, {fb, rb}, "bus b capture");
    $display("capture test done");
  endtask
  // watchdog
  initial begin
    #12000;
    n_errors++;
    wrap_up();
  end
  // main sequence
  initial begin
    clk_i = 0; rstn_i = 0; start = 0; acc_reg = 1; gear = DRGL_GEAR_1_1; delay = 4'h7;
    v_row = 4'h9; w_row = 4'h9; v_bank = 3'h2; w_bank = 3'h2; w_dev = 6'h00;
    w_pair = 0; w_core = 0; w_page = 0;
    repeat (2) @(posedge clk_i);
    #1 rstn_i = 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    t_geometry();
    t_accept();
    t_latency();
    t_ddr();
    wrap_up();
  end
endmodule // drgl_top_test
